/* hw/aim_pkg.sv */
// Package for the converter input multiplexer control block.
// Assumes an 8-bit special-function-register bus from the processor core.
package aim_pkg;
   localparam logic [7:0] ADDR_INPUT_PAIR_CONFIG = 8'hBA;
   localparam logic [7:0] ADDR_CHANNEL_SELECT = 8'hBB;
   localparam logic [7:0] ADDR_PORT_PIN_SELECT = 8'hBD;
   localparam logic [7:0] ADDR_CONV_CONFIG = 8'hBC;
   localparam logic [7:0] ADDR_CONV_CONTROL = 8'hE8;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [3:0] PAIR_CFG_MASK = 4'hF;
   localparam logic [3:0] CHAN_MASK = 4'hF;
   localparam int BIT_EXT01 = 0;
   localparam int BIT_EXT23 = 1;
   localparam int BIT_HV = 2;
   localparam int BIT_PORT = 3;
   localparam int BIT_ENABLE = 7;
   localparam int GAIN_LSB = 0;
   localparam logic [2:0] GAIN_RESET = 3'h0;
   localparam logic [2:0] GAIN_HALF = 3'h6;
   localparam logic [2:0] GAIN_UNITY = 3'h0;
   localparam logic [2:0] GAIN_X2 = 3'h1;
   localparam logic [2:0] GAIN_X4 = 3'h2;
   localparam logic [2:0] GAIN_X8 = 3'h3;
   localparam logic [2:0] GAIN_X16 = 3'h4;
   localparam int CLK_HZ = 10000000;
   localparam int SAMPLE_RATE_SPS = 100000;
   localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_RATE_SPS;
   localparam int RESULT_BITS = 12;
   localparam int SAR_STEP_CYCLES = 4;
   localparam int PORT_PINS = 8;
   localparam int PORT_EVEN = 6;
   localparam int PORT_ODD = 7;
   localparam int HV_SOURCE = 4;
   localparam int GND_SOURCE = 5;
   localparam int TEMP_SOURCE = 8;

   typedef enum logic [3:0] {
      SRC_EXT0, SRC_EXT1, SRC_EXT2, SRC_EXT3, SRC_HV, SRC_GND,
      SRC_PORT_EVEN, SRC_PORT_ODD, SRC_TEMP
   } aim_src_e;

   typedef struct packed {
      logic [3:0] pos_src;
      logic [3:0] neg_src;
      logic differential;
   } aim_route_s;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } aim_sfr_s;
endpackage

/* hw/aim_route.sv */
// Channel routing decode: select field plus pairing bits give the converter inputs.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns
module aim_route
(
   input wire logic [3:0] chan_sel,
   input wire logic [3:0] pair_cfg,
   output aim_pkg::aim_route_s route
);
   import aim_pkg::*;

   // Either member of an active pair gives the pair; gnd slot is consumed by hv pairing.
   function automatic aim_route_s pair_of(input logic [3:0] pos, input logic [3:0] neg);
      aim_route_s r;
      r.pos_src = pos;
      r.neg_src = neg;
      r.differential = 1'b1;
      return r;
   endfunction

   always_comb
   begin
      route.pos_src = chan_sel;
      route.neg_src = 4'(GND_SOURCE);
      route.differential = 1'b0;
      if (chan_sel[3])
      begin
         route.pos_src = 4'(TEMP_SOURCE);
      end
      else if (chan_sel[2:1] == 2'b00 && pair_cfg[BIT_EXT01])
      begin
         route = pair_of(4'(SRC_EXT0), 4'(SRC_EXT1));
      end
      else if (chan_sel[2:1] == 2'b01 && pair_cfg[BIT_EXT23])
      begin
         route = pair_of(4'(SRC_EXT2), 4'(SRC_EXT3));
      end
      else if (chan_sel[2:1] == 2'b10 && pair_cfg[BIT_HV])
      begin
         route = pair_of(4'(HV_SOURCE), 4'(GND_SOURCE));
      end
      else if (chan_sel[2:1] == 2'b11 && pair_cfg[BIT_PORT])
      begin
         route = pair_of(4'(PORT_EVEN), 4'(PORT_ODD));
      end
   end
endmodule

/* hw/aim_top.sv */
// Control for the converter input side: registers, routing, gain, power, results.
// Assumes the core's register bus with one-cycle read and write strobes.
// What this block does
// - Converter, track-and-hold and gain stage powered only while enable is 1.
// - Enable 0 holds the whole converter subsystem in low-power shutdown.
// - After reset every multiplexer input is an independent single-ended channel.
// - Three-bit gain field selects gain 0.5, 1, 2, 4, 8 or 16.
// - Reset sets the gain stage to unity.
// - Any combination of Port 3 pins may be enabled as inputs together.
// - Selected even pins join one input; selected odd pins join another.
// - Bit 3 pairs Port 3 even (plus) and odd (minus) channels.
// - Bit 2 makes the high-voltage amplifier result two's complement.
// - Bit 1 pairs external input 2 (plus) with input 3 (minus).
// - Bit 0 pairs external input 0 (plus) with input 1 (minus).
// - Upper four configuration bits read zero; writes to them ignored.
// - Differential channels deliver results in two's complement.
// - High-voltage amplifier output selectable like any other channel.
// - Twelve-bit successive-approximation results at up to 100 ksps.
// - Four-bit channel select with pairing bits chooses the converter input.
// - Eight pin bits; bit n connects Port 3 pin n to the multiplexer.
`timescale 1ns/1ns
module aim_top
(
   input wire logic mclk,
   input wire logic rst,
   input wire aim_pkg::aim_sfr_s sfr,
   input wire logic comp_out,
   output logic [7:0] sfr_rdata_q,
   output logic power_on_q,
   output logic [2:0] gain_sel_q,
   output logic [7:0] pin_connect_q,
   output logic even_group_on_q,
   output logic odd_group_on_q,
   output aim_pkg::aim_route_s route_q,
   output logic [11:0] dac_code_q,
   output logic sample_q,
   output logic [15:0] result_q,
   output logic result_valid_q
);
   import aim_pkg::*;

   typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_TRACK, ST_CONVERT} aim_state_e;

   logic [3:0] pair_cfg_q;
   logic [3:0] chan_sel_q;
   logic [7:0] pin_sel_q;
   logic [2:0] gain_q;
   logic enable_q;
   logic start_q;
   aim_route_s route_d;
   aim_state_e state_q;
   logic [7:0] rate_cnt_q;
   logic [3:0] bit_idx_q;
   logic [2:0] step_q;
   logic [11:0] sar_q;

   function automatic logic hit(input aim_sfr_s b, input logic [7:0] a);
      return b.wr && (b.addr == a);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register writes.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         pair_cfg_q <= 4'h0;
         chan_sel_q <= 4'h0;
         pin_sel_q <= 8'h00;
         gain_q <= GAIN_RESET;
         enable_q <= 1'b0;
         start_q <= 1'b0;
      end
      else
      begin
         start_q <= 1'b0;
         if (hit(sfr, ADDR_INPUT_PAIR_CONFIG))
         begin
            pair_cfg_q <= sfr.wdata[3:0] & PAIR_CFG_MASK;
         end
         if (hit(sfr, ADDR_CHANNEL_SELECT))
         begin
            chan_sel_q <= sfr.wdata[3:0] & CHAN_MASK;
         end
         if (hit(sfr, ADDR_PORT_PIN_SELECT))
         begin
            pin_sel_q <= sfr.wdata;
         end
         if (hit(sfr, ADDR_CONV_CONFIG))
         begin
            gain_q <= sfr.wdata[GAIN_LSB +: 3];
         end
         if (hit(sfr, ADDR_CONV_CONTROL))
         begin
            enable_q <= sfr.wdata[BIT_ENABLE];
            start_q <= sfr.wdata[0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register reads; unused bits come back as zero.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         sfr_rdata_q <= RESET_BYTE;
      end
      else if (sfr.rd)
      begin
         case (sfr.addr)
            ADDR_INPUT_PAIR_CONFIG: sfr_rdata_q <= {4'h0, pair_cfg_q};
            ADDR_CHANNEL_SELECT: sfr_rdata_q <= {4'h0, chan_sel_q};
            ADDR_PORT_PIN_SELECT: sfr_rdata_q <= pin_sel_q;
            ADDR_CONV_CONFIG: sfr_rdata_q <= {5'h00, gain_q};
            ADDR_CONV_CONTROL: sfr_rdata_q <= {enable_q, 6'h00, state_q != ST_IDLE
               && state_q != ST_OFF};
            default: sfr_rdata_q <= RESET_BYTE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Analog steering outputs, registered from the control fields in every state; only power_on_q follows enable.
   aim_route u_route
   (
      .chan_sel(chan_sel_q),
      .pair_cfg(pair_cfg_q),
      .route(route_d)
   );

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         power_on_q <= 1'b0;
         gain_sel_q <= GAIN_UNITY;
         pin_connect_q <= 8'h00;
         even_group_on_q <= 1'b0;
         odd_group_on_q <= 1'b0;
         route_q <= '{pos_src: 4'h0, neg_src: 4'(GND_SOURCE), differential: 1'b0};
      end
      else
      begin
         power_on_q <= enable_q;
         gain_sel_q <= gain_q;
         pin_connect_q <= pin_sel_q;
         // Shorting is analog; the digital side only reports which group is live.
         even_group_on_q <= |(pin_sel_q & 8'h55);
         odd_group_on_q <= |(pin_sel_q & 8'hAA);
         route_q <= route_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Conversion sequencer: one sample per rate period at most.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= ST_OFF;
         rate_cnt_q <= 8'h00;
         bit_idx_q <= 4'h0;
         step_q <= 3'h0;
         sar_q <= 12'h000;
         dac_code_q <= 12'h000;
         sample_q <= 1'b0;
         result_q <= 16'h0000;
         result_valid_q <= 1'b0;
      end
      else
      begin
         result_valid_q <= 1'b0;
         if (rate_cnt_q != 8'h00)
         begin
            rate_cnt_q <= rate_cnt_q - 8'h01;
         end
         case (state_q)
            ST_OFF:
            begin
               sample_q <= 1'b0;
               if (enable_q)
               begin
                  state_q <= ST_IDLE;
               end
            end
            ST_IDLE:
            begin
               if (!enable_q)
               begin
                  state_q <= ST_OFF;
               end
               else if (start_q && rate_cnt_q == 8'h00)
               begin
                  rate_cnt_q <= 8'(SAMPLE_CYCLES - 1);
                  sample_q <= 1'b1;
                  state_q <= ST_TRACK;
               end
            end
            ST_TRACK:
            begin
               sample_q <= 1'b0;
               bit_idx_q <= 4'(RESULT_BITS - 1);
               sar_q <= 12'h800;
               dac_code_q <= 12'h800;
               step_q <= 3'h0;
               state_q <= ST_CONVERT;
            end
            ST_CONVERT:
            begin
               if (!enable_q)
               begin
                  state_q <= ST_OFF;
               end
               else if (step_q != 3'(SAR_STEP_CYCLES - 1))
               begin
                  step_q <= step_q + 3'h1;
               end
               else
               begin
                  step_q <= 3'h0;
                  if (bit_idx_q == 4'h0)
                  begin
                     // Offset-binary to two's complement is an MSB flip.
                     // The last decision lands in bit 0 in both formats.
                     result_q <= {4'h0, (route_q.differential
                        ? {~sar_q[11], sar_q[10:1], sar_q[0] & comp_out}
                        : {sar_q[11:1], sar_q[0] & comp_out})};
                     result_valid_q <= 1'b1;
                     state_q <= ST_IDLE;
                  end
                  else
                  begin
                     sar_q[bit_idx_q] <= comp_out;
                     sar_q[bit_idx_q - 4'h1] <= 1'b1;
                     dac_code_q[bit_idx_q] <= comp_out;
                     dac_code_q[bit_idx_q - 4'h1] <= 1'b1;
                     bit_idx_q <= bit_idx_q - 4'h1;
                  end
               end
            end
            default: state_q <= ST_OFF;
         endcase
      end
   end
endmodule

/* bench/aim_comp_model.sv */
// Comparator stand-in for the analog front end of the converter.
// Assumes the SAR logic compares a held input level against dac_code_q.
`timescale 1ns/1ns
module aim_comp_model
(
   input wire logic [11:0] level,
   input wire logic [11:0] dac_code_q,
   output logic comp_out
);
   // The input sits half a step above its code so the search lands exactly on it.
   assign comp_out = ({level, 1'b1} > {dac_code_q, 1'b0});
endmodule

/* bench/aim_top_asserts.sv */
// Checker for the input mux control block, watching only the top ports.
// Assumes it is bound into aim_top.
`timescale 1ns/1ns
module aim_top_asserts
(
   input wire logic mclk,
   input wire logic rst,
   input wire aim_pkg::aim_sfr_s sfr,
   input wire logic [7:0] sfr_rdata_q,
   input wire logic power_on_q,
   input wire logic [2:0] gain_sel_q,
   input wire logic [7:0] pin_connect_q,
   input wire logic even_group_on_q,
   input wire logic odd_group_on_q,
   input wire aim_pkg::aim_route_s route_q,
   input wire logic sample_q,
   input wire logic [15:0] result_q,
   input wire logic result_valid_q
);
   import aim_pkg::*;
   logic mapped;
   assign mapped = sfr.addr inside {8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hE8};
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_track;
      sample_q;
   endsequence
   sequence s_result;
      ##[40:60] result_valid_q;
   endsequence
   chk_power_follows_enable: assert property (sfr.wr && sfr.addr == 8'hE8 |-> ##2
      power_on_q == $past(sfr.wdata[7], 2)) else $error("power does not follow enable");
   chk_shutdown_no_sample: assert property (!power_on_q |-> !sample_q)
      else $error("tracking while shut down");
   chk_gain_follows_field: assert property (sfr.wr && sfr.addr == 8'hBC |-> ##2
      gain_sel_q == $past(sfr.wdata[2:0], 2)) else $error("gain not taken");
   chk_pins_follow_write: assert property (sfr.wr && sfr.addr == 8'hBD |-> ##2
      pin_connect_q == $past(sfr.wdata, 2)) else $error("pin select not taken");
   chk_group_wired_or: assert property (even_group_on_q == |(pin_connect_q & 8'h55)
      && odd_group_on_q == |(pin_connect_q & 8'hAA)) else $error("group enable wrong");
   chk_upper_reads_zero: assert property (sfr.rd && sfr.addr inside {8'hBA, 8'hBB}
      |=> sfr_rdata_q[7:4] == 4'h0) else $error("upper bits not zero");
   chk_unmapped_read_zero: assert property (sfr.rd && !mapped |=> sfr_rdata_q == 8'h00)
      else $error("unmapped read not zero");
   chk_diff_pair_order: assert property (route_q.differential |->
      route_q.neg_src == route_q.pos_src + 4'h1 && !route_q.pos_src[0])
      else $error("pair order wrong");
   chk_result_after_track: assert property (s_track |-> s_result)
      else $error("no result after tracking");
   chk_result_twelve_bits: assert property (result_valid_q |-> result_q[15:12] == 4'h0
      ##1 !result_valid_q) else $error("result word malformed");
endmodule
bind aim_top aim_top_asserts aim_top_asserts_i (.mclk(mclk), .rst(rst), .sfr(sfr),
   .sfr_rdata_q(sfr_rdata_q), .power_on_q(power_on_q), .gain_sel_q(gain_sel_q),
   .pin_connect_q(pin_connect_q), .even_group_on_q(even_group_on_q),
   .odd_group_on_q(odd_group_on_q), .route_q(route_q), .sample_q(sample_q),
   .result_q(result_q), .result_valid_q(result_valid_q));

/* bench/aim_top_tb.sv */
// Self-checking bench for the input mux control block.
// Assumes aim_top and the comparator model; drives the register bus directly.
`timescale 1ns/1ns
module aim_top_tb;
   import aim_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   aim_sfr_s sfr = '0;
   logic comp_out;
   logic [7:0] sfr_rdata_q, pin_connect_q;
   logic power_on_q, even_group_on_q, odd_group_on_q, sample_q, result_valid_q;
   logic [2:0] gain_sel_q;
   aim_route_s route_q;
   logic [11:0] dac_code_q;
   logic [15:0] result_q;
   logic [11:0] level = 12'h5A3;
   int miscompares = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [7:0] d;
   logic [3:0] gains [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6};
   always #50 mclk = ~mclk;
   aim_top aim_top_i (.mclk(mclk), .rst(rst), .sfr(sfr), .comp_out(comp_out),
      .sfr_rdata_q(sfr_rdata_q), .power_on_q(power_on_q), .gain_sel_q(gain_sel_q),
      .pin_connect_q(pin_connect_q), .even_group_on_q(even_group_on_q),
      .odd_group_on_q(odd_group_on_q), .route_q(route_q), .dac_code_q(dac_code_q),
      .sample_q(sample_q), .result_q(result_q), .result_valid_q(result_valid_q));
   aim_comp_model aim_comp_model_i (.level(level), .dac_code_q(dac_code_q),
      .comp_out(comp_out));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      if (miscompares == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         print_verdict();
      end
   end
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      sfr <= '{1'b1, 1'b0, a, v};
      @(posedge mclk);
      sfr.wr <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge mclk);
      sfr <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge mclk);
      sfr.rd <= 1'b0;
      #1 v = sfr_rdata_q;
   endtask
   // Single-ended channels keep ground as the minus side; pairs return pos/pos+1.
   function automatic logic [8:0] exp_route(input logic [3:0] c, input logic [3:0] f);
      if (c[3])
         return {4'h8, 4'h5, 1'b0};
      if (f[c[2:1]])
         return {1'b0, c[2:1], 1'b0, 1'b0, c[2:1], 1'b1, 1'b1};
      return {c, 4'h5, 1'b0};
   endfunction
   task automatic convert(input logic [15:0] exp);
      int n;
      wr(8'hE8, 8'h81);
      for (n = 0; n < 200 && result_valid_q !== 1'b1; n++)
         @(posedge mclk) #1;
      cmp("result valid", 16'h1, result_valid_q);
      cmp("result", exp, result_q);
      repeat (100) @(posedge mclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      int n;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1 cmp("gain", 16'h0, gain_sel_q);
      cmp("power", 16'h0, power_on_q);
      cmp("route", 16'h00A, route_q);
      rd(8'hBA, d);
      cmp("pair cfg", 16'h0, d);
      wr(8'hBA, 8'hFF);
      rd(8'hBA, d);
      cmp("pair cfg", 16'h0F, d);
      rd(8'h00, d);
      cmp("unmapped", 16'h0, d);
      for (int f = 0; f < 16; f++)
         for (int c = 0; c < 9; c++)
         begin
            wr(8'hBA, 8'(f));
            wr(8'hBB, 8'(c));
            cmp("route", exp_route(4'(c), 4'(f)), route_q);
         end
      rd(8'hBB, d);
      cmp("chan sel", 16'h08, d);
      foreach (gains[i])
      begin
         wr(8'hBC, {4'h0, gains[i]});
         cmp("gain", gains[i], gain_sel_q);
      end
      rd(8'hBC, d);
      cmp("gain reg", 16'h06, d);
      wr(8'hBD, 8'h55);
      cmp("groups", 16'h0255, {even_group_on_q, odd_group_on_q, pin_connect_q});
      wr(8'hBD, 8'hAA);
      cmp("groups", 16'h01AA, {even_group_on_q, odd_group_on_q, pin_connect_q});
      rd(8'hBD, d);
      cmp("pin sel", 16'hAA, d);
      wr(8'hE8, 8'h80);
      cmp("power", 16'h1, power_on_q);
      rd(8'hE8, d);
      cmp("control", 16'h80, d);
      wr(8'hBB, 8'h00);
      wr(8'hBA, 8'h00);
      convert({4'h0, level});
      wr(8'hBA, 8'h01);
      convert({4'h0, level ^ 12'h800});
      wr(8'hBA, 8'h04);
      wr(8'hBB, 8'h04);
      convert({4'h0, level ^ 12'h800});
      wr(8'hE8, 8'h01);
      cmp("power", 16'h0, power_on_q);
      n = 0;
      repeat (100) @(posedge mclk) #1 n += int'(result_valid_q === 1'b1);
      cmp("results while off", 16'h0, 16'(n));
      print_verdict();
   end
endmodule
